// *** verilog/rpl_top.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Buffer between a receive port and its output.
// ----------------------------------------
module rpl_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic CLK, // System clock.
  input wire logic RST, // Asynchronous reset.
  input wire logic [WIDTH-1:0] IN_DATA, // Write data.
  input wire logic IN_VALID, // Write request.
  output logic IN_READY, // Room available.
  output logic [WIDTH-1:0] OUT_DATA, // Head word.
  output logic OUT_VALID, // Head word present.
  input wire logic OUT_READY // Drain side takes head.
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit.
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = wp_r == rp_r;
  assign IN_READY = !full;
  assign OUT_VALID = !empty;
  assign OUT_DATA = mem[rp_r[AW-1:0]];

  // Storage writes.
  always_ff @(posedge CLK) begin
    if (IN_VALID && !full) begin
      mem[wp_r[AW-1:0]] <= IN_DATA;
    end
  end

  // Pointer updates.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (IN_VALID && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (OUT_READY && !empty) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // rpl_fifo

`timescale 1ns/1ps
// ----------------------------------------
// Receive port control, lock and pass status.
// ----------------------------------------
module rpl_top
  import rpl_pkg::*;
#(
  parameter logic [6:0] MAIN_ID = 7'h30, // Arbitrary value.
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CLK, // 50 MHz clock.
  input wire logic RST, // Asynchronous reset.
  input wire logic REG_REQ, // Register access strobe.
  input rpl_req_s REG_CMD, // Access fields.
  output logic REG_ACK, // Answer strobe.
  output logic REG_HIT, // Address was ours.
  output logic [7:0] REG_RDATA, // Read data.
  input wire logic [1:0] LINK_SYNC, // Receiver in sync.
  input wire logic [1:0] LINK_BIT_ERR, // Link bit error pulse.
  input wire logic [1:0] SER_PCLK_ACT, // Remote pixel clock active.
  output logic [1:0] RX_RESTART, // Receiver reset request.
  output logic [1:0] PORT_LOCK_GPIO, // Per-port lock flag.
  output logic [1:0] REMOTE_I2C_EN, // Remote access allowed.
  output logic LOCK, // Selected lock pin.
  output logic PASS, // Selected pass pin.
  input rpl_beat_s [1:0] VID_IN, // Incoming video beats.
  input wire logic [1:0] VID_IN_VALID, // Beat valid.
  output logic [1:0] VID_IN_READY, // Beat taken.
  output rpl_beat_s [1:0] VID_OUT, // Forwarded beats.
  output logic [1:0] VID_OUT_VALID, // Forwarded beat valid.
  input wire logic [1:0] VID_OUT_READY // Sink takes beat.
);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic src_sel(input logic [1:0] s, input logic [1:0] v,
                                   input logic [1:0] en);
    case (s)
      2'h0: src_sel = v[0];
      2'h1: src_sel = v[1];
      2'h2: src_sel = |(v & en);
      default: src_sel = (en != 2'h0) && ((v & en) == en);
    endcase
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] rx_ctl_r;
  logic [7:0] fwd_ctl_r;
  logic [7:0] page_sel_r;
  logic [7:0] pcfg_r [2];
  logic [7:0] pass_cfg_r [2];
  logic [6:0] port_id_r [2];
  logic [1:0] port_en;
  logic [1:0] id_port;
  logic id_main;
  logic hit;
  logic [1:0] wmask;
  logic rport;
  logic [7:0] rd_nxt;
  logic [1:0] lock_flag;
  logic [1:0] lock_pin;
  logic [1:0] pass_r;
  logic [1:0] fwd_frame_r;

  assign port_en = rx_ctl_r[RXC_EN +: 2];
  assign id_main = REG_CMD.dev_id == MAIN_ID;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      id_port[p] = (port_id_r[p] != RST_PORT_ID) && (REG_CMD.dev_id == port_id_r[p]);
    end
  end
  assign hit = id_main || (id_port != 2'h0);

  // Port addresses bypass paging; the main address follows the page select.
  always_comb begin
    wmask = page_sel_r[1:0];
    rport = page_sel_r[PSEL_RD];
    if (id_port[0]) begin
      wmask = 2'h1;
      rport = 1'b0;
    end else if (id_port[1]) begin
      wmask = 2'h2;
      rport = 1'b1;
    end
  end

  // Shared registers; every address we match reaches them.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_ctl_r <= RST_RX_CTL;
      fwd_ctl_r <= RST_FWD_CTL;
      page_sel_r <= RST_PAGE_SEL;
      port_id_r[0] <= RST_PORT_ID;
      port_id_r[1] <= RST_PORT_ID;
    end else if (REG_REQ && REG_CMD.we && hit) begin
      case (REG_CMD.addr)
        ADDR_RX_CTL: begin
          rx_ctl_r[7:2] <= REG_CMD.wdata[7:2];
          if (!REG_CMD.remote) begin
            rx_ctl_r[1:0] <= REG_CMD.wdata[1:0];
          end
        end
        ADDR_FWD_CTL: fwd_ctl_r <= REG_CMD.wdata;
        ADDR_PAGE_SEL: page_sel_r <= REG_CMD.wdata;
        ADDR_PORT_ID0: port_id_r[0] <= REG_CMD.wdata[6:0];
        ADDR_PORT_ID1: port_id_r[1] <= REG_CMD.wdata[6:0];
        default: ;
      endcase
    end
  end

  // Private per-port registers, written through the page mask.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < 2; p++) begin
        pcfg_r[p] <= RST_PORT_CFG;
        pass_cfg_r[p] <= RST_PASS_CFG;
      end
    end else if (REG_REQ && REG_CMD.we && hit) begin
      for (int p = 0; p < 2; p++) begin
        if (wmask[p] && REG_CMD.addr == ADDR_PORT_CFG) begin
          pcfg_r[p] <= REG_CMD.wdata;
        end
        if (wmask[p] && REG_CMD.addr == ADDR_PASS_CFG) begin
          pass_cfg_r[p] <= REG_CMD.wdata;
        end
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_nxt = 8'h00;
    case (REG_CMD.addr)
      ADDR_DEV_STS: begin
        rd_nxt[STS_LOCK] = LOCK;
        rd_nxt[STS_PASS] = PASS;
      end
      ADDR_RX_CTL: rd_nxt = rx_ctl_r;
      ADDR_FWD_CTL: rd_nxt = fwd_ctl_r;
      ADDR_PAGE_SEL: rd_nxt = page_sel_r;
      ADDR_PORT_STS1: begin
        rd_nxt[STS_LOCK] = lock_flag[rport];
        rd_nxt[STS_PASS] = pass_r[rport];
        rd_nxt[STS_PIN] = lock_pin[rport];
        rd_nxt[STS_FWD] = fwd_frame_r[rport];
      end
      ADDR_PORT_CFG: rd_nxt = pcfg_r[rport];
      ADDR_PASS_CFG: rd_nxt = pass_cfg_r[rport];
      ADDR_PORT_ID0: rd_nxt = {1'b0, port_id_r[0]};
      ADDR_PORT_ID1: rd_nxt = {1'b0, port_id_r[1]};
      default: rd_nxt = 8'h00;
    endcase
  end

  // Answer one cycle after each request.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_ACK <= 1'b0;
      REG_HIT <= 1'b0;
      REG_RDATA <= 8'h00;
    end else begin
      REG_ACK <= REG_REQ;
      REG_HIT <= REG_REQ && hit;
      if (REG_REQ && hit && !REG_CMD.we) begin
        REG_RDATA <= rd_nxt;
      end
    end
  end

  // ----------------------------------------
  // Lock detection
  // ----------------------------------------
  rpl_lock_e lk_st_r [2];
  logic [15:0] lk_cnt_r [2];
  logic [15:0] win_cnt_r [2];
  logic [3:0] err_cnt_r [2];
  logic [1:0] err_lim;
  logic [1:0] lost;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      lock_flag[p] = lk_st_r[p] == LK_LOCKED;
      err_lim[p] = pcfg_r[p][PCFG_ERRCHK] && (err_cnt_r[p] >= ERR_LIMIT);
      lost[p] = lock_flag[p] && (!LINK_SYNC[p] || err_lim[p] || !port_en[p]);
      RX_RESTART[p] = lk_st_r[p] == LK_RESTART;
    end
  end

  // Acquire, hold and restart sequence per port.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < 2; p++) begin
        lk_st_r[p] <= LK_RESTART;
        lk_cnt_r[p] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        case (lk_st_r[p])
          LK_RESTART: begin
            if (lk_cnt_r[p] >= 16'(RX_RST_CYC - 1)) begin
              lk_st_r[p] <= LK_ACQ;
              lk_cnt_r[p] <= 16'h0000;
            end else begin
              lk_cnt_r[p] <= lk_cnt_r[p] + 16'h0001;
            end
          end
          LK_ACQ: begin
            if (!LINK_SYNC[p] || !port_en[p]) begin
              lk_cnt_r[p] <= 16'h0000;
            end else if (lk_cnt_r[p] >= 16'(LOCK_STABLE_CYC - 1)) begin
              lk_st_r[p] <= LK_LOCKED;
              lk_cnt_r[p] <= 16'h0000;
            end else begin
              lk_cnt_r[p] <= lk_cnt_r[p] + 16'h0001;
            end
          end
          LK_LOCKED: begin
            if (lost[p]) begin
              lk_st_r[p] <= LK_RESTART;
            end
          end
          default: lk_st_r[p] <= LK_RESTART;
        endcase
      end
    end
  end

  // Bit errors counted in fixed windows while locked.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < 2; p++) begin
        win_cnt_r[p] <= 16'h0000;
        err_cnt_r[p] <= 4'h0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!lock_flag[p] || win_cnt_r[p] >= 16'(ERR_WIN_CYC - 1)) begin
          win_cnt_r[p] <= 16'h0000;
          err_cnt_r[p] <= 4'h0;
        end else begin
          win_cnt_r[p] <= win_cnt_r[p] + 16'h0001;
          if (LINK_BIT_ERR[p] && err_cnt_r[p] != 4'hF) begin
            err_cnt_r[p] <= err_cnt_r[p] + 4'h1;
          end
        end
      end
    end
  end

  // Pin-level lock qualifies by mode and remote pixel clock.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (rpl_mode_e'(pcfg_r[p][PCFG_MODE +: 2]) == MODE_RAW12HF) begin
        lock_pin[p] = lock_flag[p] && SER_PCLK_ACT[p];
      end else begin
        lock_pin[p] = lock_flag[p];
      end
    end
  end

  // Status pins and per-port indications.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LOCK <= 1'b0;
      PASS <= 1'b0;
      PORT_LOCK_GPIO <= 2'h0;
      REMOTE_I2C_EN <= 2'h0;
    end else begin
      LOCK <= src_sel(rx_ctl_r[RXC_LSEL +: 2], lock_pin, port_en);
      PASS <= src_sel(rx_ctl_r[RXC_PSEL +: 2], pass_r, port_en);
      PORT_LOCK_GPIO <= lock_flag;
      REMOTE_I2C_EN <= lock_flag;
    end
  end

  // ----------------------------------------
  // Frame checking and pass
  // ----------------------------------------
  logic [1:0] fire;
  logic [1:0] eol_any;
  logic [15:0] ll_cnt_r [2];
  logic [15:0] ll_prev_r [2];
  logic [15:0] lc_cnt_r [2];
  logic [15:0] lc_prev_r [2];
  logic [1:0] have_ll_r;
  logic [1:0] have_lc_r;
  logic [1:0] bad_r;
  logic [3:0] good_cnt_r [2];
  logic [1:0] len_bad;
  logic [1:0] lines_bad;
  logic [1:0] frame_ok;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      fire[p] = VID_IN_VALID[p] && VID_IN_READY[p];
      eol_any[p] = VID_IN[p].eol || VID_IN[p].eof;
      len_bad[p] = pass_cfg_r[p][PASS_CLEN] && have_ll_r[p] &&
                   (ll_cnt_r[p] + 16'h0001 != ll_prev_r[p]);
      lines_bad[p] = pass_cfg_r[p][PASS_CLINES] && have_lc_r[p] &&
                     (lc_cnt_r[p] + 16'h0001 != lc_prev_r[p]);
      frame_ok[p] = !bad_r[p] && !len_bad[p] && !lines_bad[p] &&
                    !(pass_cfg_r[p][PASS_CERR] && LINK_BIT_ERR[p]);
    end
  end

  // Line length, line count and error tracking per frame.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < 2; p++) begin
        ll_cnt_r[p] <= 16'h0000;
        ll_prev_r[p] <= 16'h0000;
        lc_cnt_r[p] <= 16'h0000;
        lc_prev_r[p] <= 16'h0000;
        good_cnt_r[p] <= 4'h0;
      end
      have_ll_r <= 2'h0;
      have_lc_r <= 2'h0;
      bad_r <= 2'h0;
      pass_r <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!lock_flag[p]) begin
          good_cnt_r[p] <= 4'h0;
          pass_r[p] <= 1'b0;
          have_ll_r[p] <= 1'b0;
          have_lc_r[p] <= 1'b0;
        end else begin
          if (LINK_BIT_ERR[p] && pass_cfg_r[p][PASS_CERR]) begin
            bad_r[p] <= 1'b1;
          end
          if (fire[p]) begin
            ll_cnt_r[p] <= eol_any[p] ? 16'h0000 : ll_cnt_r[p] + 16'h0001;
          end
          if (fire[p] && eol_any[p]) begin
            ll_prev_r[p] <= ll_cnt_r[p] + 16'h0001;
            have_ll_r[p] <= 1'b1;
            lc_cnt_r[p] <= lc_cnt_r[p] + 16'h0001;
            if (len_bad[p]) begin
              bad_r[p] <= 1'b1;
            end
          end
          if (fire[p] && VID_IN[p].eof) begin
            lc_cnt_r[p] <= 16'h0000;
            lc_prev_r[p] <= lc_cnt_r[p] + 16'h0001;
            have_lc_r[p] <= 1'b1;
            bad_r[p] <= 1'b0;
            if (frame_ok[p]) begin
              if (good_cnt_r[p] != 4'hF) begin
                good_cnt_r[p] <= good_cnt_r[p] + 4'h1;
              end
              if (good_cnt_r[p] + 4'h1 >= pass_cfg_r[p][PASS_THR +: 4]) begin
                pass_r[p] <= 1'b1;
              end
            end else begin
              good_cnt_r[p] <= 4'h0;
              pass_r[p] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Forwarding and truncation
  // ----------------------------------------
  logic [1:0] in_frame_r;
  logic [1:0] hold_r;
  logic [1:0] trunc_pend_r;
  logic [1:0] gate;
  logic [1:0] fwd_beat;
  logic [1:0] fifo_rdy;
  rpl_beat_s [1:0] push;

  // Forwarding permission sampled at each frame start.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      gate[p] = port_en[p] && fwd_ctl_r[p] && !hold_r[p] &&
                (!pcfg_r[p][PCFG_NLOCK] || lock_flag[p]) &&
                (!pcfg_r[p][PCFG_WPASS] || pass_r[p]);
      fwd_beat[p] = in_frame_r[p] ? fwd_frame_r[p] : gate[p];
      VID_IN_READY[p] = fwd_beat[p] ? fifo_rdy[p] : 1'b1;
      push[p] = VID_IN[p];
      push[p].trunc = 1'b0;
      if (trunc_pend_r[p] || LINK_BIT_ERR[p] || lost[p]) begin
        push[p].eof = 1'b1;
        push[p].trunc = 1'b1;
      end
    end
  end

  // Frame tracking, truncation and resume after lock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_frame_r <= 2'h0;
      fwd_frame_r <= 2'h0;
      hold_r <= 2'h0;
      trunc_pend_r <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (lost[p]) begin
          hold_r[p] <= 1'b1;
        end else if (lock_flag[p]) begin
          hold_r[p] <= 1'b0;
        end
        if (fire[p]) begin
          in_frame_r[p] <= !VID_IN[p].eof;
          if (!in_frame_r[p]) begin
            fwd_frame_r[p] <= gate[p] && !push[p].eof;
          end else if (push[p].eof) begin
            fwd_frame_r[p] <= 1'b0;
          end
          trunc_pend_r[p] <= 1'b0;
        end else if (fwd_frame_r[p] && (LINK_BIT_ERR[p] || lost[p])) begin
          trunc_pend_r[p] <= 1'b1;
        end
      end
    end
  end

  // One buffer per port in the forwarded path.
  for (genvar g = 0; g < 2; g++) begin : g_buf
    rpl_fifo #(
      .WIDTH($bits(rpl_beat_s)),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .CLK(CLK),
      .RST(RST),
      .IN_DATA(push[g]),
      .IN_VALID(VID_IN_VALID[g] && fwd_beat[g]),
      .IN_READY(fifo_rdy[g]),
      .OUT_DATA(VID_OUT[g]),
      .OUT_VALID(VID_OUT_VALID[g]),
      .OUT_READY(VID_OUT_READY[g])
    );
  end
endmodule // rpl_top

// *** verilog/rpl_pkg.sv ***
// Contract
// - Input control register disables either receive port.
// - Port disable bits change only from local writes.
// - Page select picks port for private accesses.
// - Page select defaults to port zero registers.
// - Per-port 7-bit address reaches private and shared.
// - Forwarding disabled after reset until enabled.
// - Lock and pass pins plus device status.
// - Two-bit selectors: port0, port1, OR, AND.
// - Lock asserted only after synchronization is stable.
// - Optional bit-error check inside lock detection.
// - Port lock status in status bit zero.
// - Port lock may condition video forwarding.
// - Raw12 high-freq lock pin needs active pixel clock.
// - Port lock bit high on any serializer link.
// - Lock bit high opens remote access.
// - Raw10 lock pin high whenever link exists.
// - Lock loss restarts receiver acquisition sequence.
// - Errored frames truncated; resume after lock returns.
// - Pass after programmed count of valid frames.
// - Forwarding may wait for pass conditions.
package rpl_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DEV_STS = 8'h04;
  localparam logic [7:0] ADDR_RX_CTL = 8'h0C;
  localparam logic [7:0] ADDR_FWD_CTL = 8'h20;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h4C;
  localparam logic [7:0] ADDR_PORT_STS1 = 8'h4D;
  localparam logic [7:0] ADDR_PORT_CFG = 8'h58;
  localparam logic [7:0] ADDR_PASS_CFG = 8'h59;
  localparam logic [7:0] ADDR_PORT_ID0 = 8'hF8;
  localparam logic [7:0] ADDR_PORT_ID1 = 8'hF9;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_RX_CTL = 8'h03;
  localparam logic [7:0] RST_FWD_CTL = 8'h00;
  localparam logic [7:0] RST_PAGE_SEL = 8'h01;
  localparam logic [7:0] RST_PORT_CFG = 8'h04;
  localparam logic [7:0] RST_PASS_CFG = 8'h13;
  localparam logic [6:0] RST_PORT_ID = 7'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RXC_EN = 0;
  localparam int RXC_LSEL = 2;
  localparam int RXC_PSEL = 4;
  localparam int PSEL_RD = 4;
  localparam int PCFG_ERRCHK = 0;
  localparam int PCFG_WPASS = 1;
  localparam int PCFG_NLOCK = 2;
  localparam int PCFG_MODE = 4;
  localparam int PASS_THR = 0;
  localparam int PASS_CERR = 4;
  localparam int PASS_CLEN = 5;
  localparam int PASS_CLINES = 6;
  localparam int STS_LOCK = 0;
  localparam int STS_PASS = 1;
  localparam int STS_PIN = 2;
  localparam int STS_FWD = 3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int LOCK_STABLE_US = 10;
  localparam int LOCK_STABLE_CYC = LOCK_STABLE_US * CLK_MHZ;
  localparam int RX_RST_NS = 1000;
  localparam int RX_RST_CYC = (RX_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int ERR_WIN_US = 20;
  localparam int ERR_WIN_CYC = ERR_WIN_US * CLK_MHZ;
  localparam logic [3:0] ERR_LIMIT = 4'h4;
  localparam int VID_DATA_W = 16;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_CSI, MODE_RAW10, MODE_RAW12HF, MODE_RAW12LF} rpl_mode_e;
  typedef enum logic [1:0] {LK_RESTART, LK_ACQ, LK_LOCKED} rpl_lock_e;
  typedef struct packed {
    logic [VID_DATA_W-1:0] data;
    logic eol;
    logic eof;
    logic trunc;
  } rpl_beat_s;
  typedef struct packed {
    logic we;
    logic remote;
    logic [6:0] dev_id;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpl_req_s;
endpackage

// *** tb/rpl_chk.sv ***
`timescale 1ns/1ps
// ------
// Watcher on the top module ports.
// ------
module rpl_chk (
  input wire logic CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic REG_REQ, // Access strobe.
  input wire logic REG_ACK, // Answer strobe.
  input wire logic REG_HIT, // Address match.
  input wire logic [7:0] REG_RDATA, // Read data.
  input wire logic [1:0] LINK_SYNC, // Sync in.
  input wire logic [1:0] RX_RESTART, // Restart out.
  input wire logic [1:0] PORT_LOCK_GPIO, // Lock flag out.
  input wire logic [1:0] REMOTE_I2C_EN, // Remote access out.
  input wire logic [1:0] VID_OUT_VALID // Output beat valid.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [9:0] sync_run_r;
  // Counts consecutive sync cycles on port zero, saturating.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_run_r <= 10'h000;
    end else if (!LINK_SYNC[0]) begin
      sync_run_r <= 10'h000;
    end else if (sync_run_r != 10'h3FF) begin
      sync_run_r <= sync_run_r + 10'h001;
    end
  end
  // A restart must last well beyond a glitch.
  sequence s_restart_hold;
    RX_RESTART[0] [*8];
  endsequence
  AST_ACK: assert property (REG_REQ |=> REG_ACK)
    else $error("missing answer");
  AST_RDATA_HOLD: assert property (REG_ACK && !REG_HIT |-> $stable(REG_RDATA))
    else $error("read data moved on a miss");
  AST_COPY: assert property (PORT_LOCK_GPIO == REMOTE_I2C_EN)
    else $error("remote access differs from lock");
  AST_LOCK_STABLE: assert property ($rose(PORT_LOCK_GPIO[0]) |-> sync_run_r >= 10'h1F4)
    else $error("lock before stable sync");
  AST_SYNC_DROP: assert property (PORT_LOCK_GPIO[0] && !LINK_SYNC[0] |-> ##[1:3] !PORT_LOCK_GPIO[0])
    else $error("lock kept without sync");
  AST_RESTART: assert property ($fell(PORT_LOCK_GPIO[0]) |-> ##[0:2] RX_RESTART[0])
    else $error("no restart on lock loss");
  AST_RESTART_LEN: assert property ($rose(RX_RESTART[0]) |-> s_restart_hold)
    else $error("restart too short");
  AST_FWD_RESET: assert property ($fell(RST) |-> (VID_OUT_VALID == 2'b00) [*8])
    else $error("video forwarded after reset");
endmodule // rpl_chk

// *** tb/rpl_ser.sv ***
`timescale 1ns/1ps
// ------
// Remote serializer seen from one receive port.
// ------
module rpl_ser
  import rpl_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic link_on, // Link present.
  input wire logic pclk_on, // Pixel clock present.
  input wire logic send, // Start a frame.
  output logic sync, // Receiver sync.
  output logic pclk_act, // Pixel clock active.
  output rpl_beat_s beat = '0, // Video beat.
  output logic valid, // Beat valid.
  input wire logic ready // Beat taken.
);
  logic [2:0] left_r = 3'h0;
  assign sync = link_on;
  assign pclk_act = link_on & pclk_on;
  assign valid = left_r != 3'h0;
  // Four-beat frame held until taken; idle data toggles.
  always_ff @(posedge clk) begin
    if (send && !valid) begin
      left_r <= 3'h4;
      beat <= '{data: 16'hA500, eol: 1'b0, eof: 1'b0, trunc: 1'b0};
    end else if (valid && ready) begin
      left_r <= left_r - 3'h1;
      beat.data <= beat.data + 16'h0001;
      beat.eof <= left_r == 3'h2;
    end else if (!valid) begin
      beat.data <= ~beat.data;
    end
  end
endmodule // rpl_ser

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rpl_pkg::*;
  localparam logic [6:0] ID = 7'h30; // Arbitrary value.
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, ack, hit, lock, pass, hit_s;
  rpl_req_s cmd = '0;
  logic [7:0] rdata;
  logic [1:0] link_on = 2'b00, pclk_on = 2'b00, send = 2'b00, berr = 2'b00, irdy, gpio, ovld, rs;
  wire [1:0] sync, pclk, ivld;
  wire rpl_beat_s [1:0] vin;
  rpl_beat_s [1:0] vout;
  rpl_beat_s last;
  int mismatches = 0, check_count = 0, got = 0;
  rpl_top #(.MAIN_ID(ID)) dut_u (.CLK(clk), .RST(rst), .REG_REQ(req), .REG_CMD(cmd),
    .REG_ACK(ack), .REG_HIT(hit), .REG_RDATA(rdata), .LINK_SYNC(sync), .LINK_BIT_ERR(berr),
    .SER_PCLK_ACT(pclk), .RX_RESTART(rs), .PORT_LOCK_GPIO(gpio), .REMOTE_I2C_EN(), .LOCK(lock),
    .PASS(pass), .VID_IN(vin), .VID_IN_VALID(ivld), .VID_IN_READY(irdy), .VID_OUT(vout),
    .VID_OUT_VALID(ovld), .VID_OUT_READY(2'b11));
  rpl_ser ser0_u (.clk(clk), .link_on(link_on[0]), .pclk_on(pclk_on[0]), .send(send[0]),
    .sync(sync[0]), .pclk_act(pclk[0]), .beat(vin[0]), .valid(ivld[0]), .ready(irdy[0]));
  rpl_ser ser1_u (.clk(clk), .link_on(link_on[1]), .pclk_on(pclk_on[1]), .send(send[1]),
    .sync(sync[1]), .pclk_act(pclk[1]), .beat(vin[1]), .valid(ivld[1]), .ready(irdy[1]));
  // ------
  // Clock, beat counter and watchdog.
  // ------
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (ovld[0]) begin got++; last = vout[0]; end
  initial begin repeat (5000) @(posedge clk); mismatches++; conclude(); end
  task automatic chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin mismatches++; $display("unexpected %0t got %h exp %h", $time, g, e); end
  endtask
  // One register access; the answer is taken at the edge that samples it, hit kept in hit_s.
  task automatic acc(input logic we, rm, input logic [6:0] id, input logic [7:0] a, d);
    @(posedge clk);
    req <= 1'b1;
    cmd <= '{we: we, remote: rm, dev_id: id, addr: a, wdata: d};
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    hit_s = hit;
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic t_reset();
    logic [7:0] a [5] = '{ADDR_RX_CTL, ADDR_FWD_CTL, ADDR_PAGE_SEL, ADDR_DEV_STS, 8'h10};
    logic [7:0] e [5] = '{RST_RX_CTL, RST_FWD_CTL, RST_PAGE_SEL, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin acc(0, 0, ID, a[i], 0); chk(rdata, e[i]); end
    $display("reset values done");
  endtask
  task automatic t_ctl();
    acc(1, 1, ID, ADDR_RX_CTL, 8'h00);
    acc(0, 0, ID, ADDR_RX_CTL, 0); chk(rdata, 8'h03);
    acc(1, 0, ID, ADDR_RX_CTL, 8'h00);
    acc(0, 0, ID, ADDR_RX_CTL, 0); chk(rdata, 8'h00);
    acc(1, 0, ID, ADDR_RX_CTL, 8'h03);
    acc(0, 0, 7'h11, ADDR_RX_CTL, 0); chk({7'h00, hit_s}, 8'h00);
    $display("control done");
  endtask
  task automatic t_lock();
    link_on <= 2'b01; pclk_on <= 2'b01;
    for (int i = 0; i < 800 && gpio[0] !== 1'b1; i++) @(negedge clk);
    chk({6'h00, gpio}, 8'h01);
    acc(0, 0, ID, ADDR_DEV_STS, 0); chk(rdata & 8'h01, 8'h01);
    for (int s = 0; s < 4; s++) begin
      acc(1, 0, ID, ADDR_RX_CTL, {4'h0, s[1:0], 2'b11});
      repeat (2) @(negedge clk); chk({7'h00, lock}, {7'h00, ~s[0]});
    end
    acc(1, 0, ID, ADDR_RX_CTL, 8'h03);
    acc(1, 0, ID, ADDR_PAGE_SEL, 8'h11);
    acc(0, 0, ID, ADDR_PORT_STS1, 0); chk(rdata & 8'h01, 8'h00);
    acc(1, 0, ID, ADDR_PAGE_SEL, 8'h01);
    acc(0, 0, ID, ADDR_PORT_STS1, 0); chk(rdata & 8'h01, 8'h01);
    acc(1, 0, ID, ADDR_PORT_ID1, 8'h25);
    acc(0, 0, 7'h25, ADDR_PORT_STS1, 0); chk({rdata[0], hit_s}, 8'h01);
    acc(0, 0, 7'h25, ADDR_RX_CTL, 0); chk(rdata, 8'h03);
    $display("lock done");
  endtask
  task automatic t_mode();
    pclk_on <= 2'b00;
    acc(1, 0, ID, ADDR_PORT_CFG, 8'h24);
    repeat (3) @(negedge clk); chk({7'h00, lock}, 8'h00);
    acc(0, 0, ID, ADDR_PORT_STS1, 0); chk(rdata & 8'h01, 8'h01);
    acc(1, 0, ID, ADDR_PORT_CFG, 8'h14);
    repeat (3) @(negedge clk); chk({7'h00, lock}, 8'h01);
    acc(1, 0, ID, ADDR_PORT_CFG, RST_PORT_CFG);
    $display("mode done");
  endtask
  task automatic t_video();
    // Frames 0-2 are clean, frame 3 carries a bit error on its second beat.
    for (int f = 0; f < 4; f++) begin
      send <= 2'b01; @(posedge clk); send <= 2'b00;
      @(posedge clk); berr <= {1'b0, f == 3};
      @(posedge clk); berr <= 2'b00;
      repeat (12) @(negedge clk);
      chk(got[7:0], f == 3 ? 8'h0A : 8'(4 * f));
      chk({7'h00, pass}, {7'h00, f == 2});
      acc(1, 0, ID, ADDR_FWD_CTL, 8'h01);
    end
    chk({6'h00, last.trunc, last.eof}, 8'h03);
    link_on <= 2'b00; repeat (4) @(negedge clk);
    chk({6'h00, gpio[0], rs[0]}, 8'h01);
    $display("video done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset(); t_ctl(); t_lock(); t_mode(); t_video();
    conclude();
  end
endmodule // tb_top
bind rpl_top rpl_chk chk_u (.CLK, .RST, .REG_REQ, .REG_ACK, .REG_HIT, .REG_RDATA,
  .LINK_SYNC, .RX_RESTART, .PORT_LOCK_GPIO, .REMOTE_I2C_EN, .VID_OUT_VALID);
